// ---- rtl/wwrs_pkg.sv ----
// Purpose: constants and types for the windowed watchdog reset supervisor
// Assumes: core_clk at 100 MHz
// Notes:   window option tables give microseconds, converted to counts of a 10 us timebase tick
`default_nettype none
package wwrs_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_US         = 10;
  localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
  // wide enough for the longest slow window in ticks
  localparam int unsigned TCNT_W          = 23;

  // fault pulse, reset timeout and manual reset timing
  localparam int unsigned FAULT_PULSE_US  = 1000;
  localparam int unsigned RESET_TMO_MS    = 100;
  localparam int unsigned MR_MIN_NS       = 1000;
  localparam int unsigned MR_MIN_CYC      = (MR_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FAULT_TICKS     = FAULT_PULSE_US / TICK_US;
  localparam int unsigned RESET_TICKS     = RESET_TMO_MS * 1000 / TICK_US;

  // window options A..H, fast limit max and slow limit min in microseconds
  typedef logic [2:0] wwrs_opt_t;
  localparam logic [31:0] FAST_US [8] = '{32'h0000_05DC, 32'h0000_3A98, 32'h0000_3A98, 32'h0000_3A98,
                                           32'h0000_3A98, 32'h0000_59D8, 32'h0000_9858, 32'h000A_F8B8};
  localparam logic [31:0] SLOW_US [8] = '{32'h0000_2710, 32'h0001_86A0, 32'h0004_93E0, 32'h0098_9680,
                                           32'h0393_8700, 32'h0000_B798, 32'h0001_4050, 32'h0013_D620};

  typedef enum logic [2:0] {
    WD_ARMED = 3'b001,
    WD_RUN   = 3'b010,
    WD_FAULT = 3'b100
  } wwrs_wd_state_t;

  typedef struct packed {
    logic kick;
    logic mr_n;
  } wwrs_sync_t;

endpackage
`default_nettype wire

// ---- rtl/wwrs_sync.sv ----
// Purpose: two-flop synchroniser bank for pin inputs
// Assumes: inputs asynchronous to core_clk
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module wwrs_sync
  import wwrs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire wwrs_sync_t async_in,
  output var  wwrs_sync_t sync_out
);

  wwrs_sync_t meta;
  wwrs_sync_t next_meta;
  wwrs_sync_t next_sync;

  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  // idle-high reset value keeps a fake edge out of release
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta     <= '{kick: 1'b1, mr_n: 1'b1};
      sync_out <= '{kick: 1'b1, mr_n: 1'b1};
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/wwrs_top.sv ----
// Purpose: windowed watchdog with reset generator
// Assumes: supply_ok comes from an analog comparator, active high
// Notes:   all timing from a free-running 10 us tick except the manual reset filter, which counts core_clk cycles
//
// How it works
// - the interval timer clears on an in-window falling edge and when reset or fault pulse deasserts.
// - a falling edge inside the window produces no fault pulse.
// - an edge too early or a missing edge too late drives the fault pulse low for about 1 ms.
// - two falling edges closer than the fast limit raise a fast fault.
// - no falling edge before the slow limit raises a slow fault.
// - the fault pulse stays inactive while reset is asserted.
// - watchdog input pulses are ignored while reset or fault pulse is asserted.
// - the first falling edge after reset or fault pulse deasserts skips the fast check.
// - a watchdog fault by itself never asserts reset.
// - reset asserts on supply undervoltage or a held-low manual reset input.
// - reset stays asserted at least 100 ms after supply is good and manual reset released.
// - manual reset lows shorter than 1 us are rejected as glitches.
// - a fault pulse looped to manual reset yields a full reset timeout.
`timescale 1ns/100ps
`default_nettype none
module wwrs_top
  import wwrs_pkg::*;
#(
  parameter wwrs_opt_t          WINDOW_OPT  = 3'h0,
  parameter logic [TCNT_W-1:0]  FAULT_LEN   = TCNT_W'(FAULT_TICKS),
  parameter logic [TCNT_W-1:0]  RESET_LEN   = TCNT_W'(RESET_TICKS),
  parameter logic [TCNT_W-1:0]  TICK_LEN    = TCNT_W'(TICK_CYC)
)(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic supply_ok,
  input  wire logic watchdog_kick_in,
  input  wire logic manual_reset_n,
  output logic      reset_n,
  output logic      watchdog_fault_pulse_n
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [TCNT_W-1:0] us_to_ticks(input logic [31:0] us);
    us_to_ticks = TCNT_W'(us / TICK_US);
  endfunction

  localparam logic [TCNT_W-1:0] FAST_LIM = us_to_ticks(FAST_US[WINDOW_OPT]);
  localparam logic [TCNT_W-1:0] SLOW_LIM = us_to_ticks(SLOW_US[WINDOW_OPT]);

  // ----------------------------------------
  // input sync and timebase
  // ----------------------------------------
  wwrs_sync_t pins;
  wwrs_sync_t syn;
  logic       supply_meta;
  logic       supply_sync;
  logic [TCNT_W-1:0] tick_cnt;
  logic [TCNT_W-1:0] next_tick_cnt;
  logic       tick;
  logic       kick_d;
  logic       kick_fall;

  assign pins = '{kick: watchdog_kick_in, mr_n: manual_reset_n};

  wwrs_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (pins),
    .sync_out (syn)
  );

  assign tick      = (tick_cnt == TICK_LEN - 1'b1);
  assign kick_fall = kick_d & ~syn.kick;

  always_comb begin
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_cnt    <= '0;
      kick_d      <= 1'b1;
      supply_meta <= 1'b0;
      supply_sync <= 1'b0;
    end else begin
      tick_cnt    <= next_tick_cnt;
      kick_d      <= syn.kick;
      supply_meta <= supply_ok;
      supply_sync <= supply_meta;
    end
  end

  // ----------------------------------------
  // manual reset filter and reset timeout
  // ----------------------------------------
  logic [7:0]        mr_low_cnt;
  logic [7:0]        next_mr_low_cnt;
  logic              mr_hold;
  logic              next_mr_hold;
  logic [TCNT_W-1:0] rst_cnt;
  logic [TCNT_W-1:0] next_rst_cnt;
  logic              next_reset_n;
  logic              rst_cause;

  // glitch filter: reset only after the input stays low the full minimum width
  always_comb begin
    next_mr_low_cnt = syn.mr_n ? 8'h00 : mr_low_cnt;
    next_mr_hold    = mr_hold;
    if (!syn.mr_n && mr_low_cnt != 8'(MR_MIN_CYC)) begin
      next_mr_low_cnt = mr_low_cnt + 8'h01;
    end
    if (!syn.mr_n && mr_low_cnt == 8'(MR_MIN_CYC - 1)) begin
      next_mr_hold = 1'b1;
    end else if (syn.mr_n) begin
      next_mr_hold = 1'b0;
    end
  end

  assign rst_cause = ~supply_sync | mr_hold;

  always_comb begin
    next_rst_cnt = rst_cnt;
    next_reset_n = reset_n;
    if (rst_cause) begin
      next_rst_cnt = '0;
      next_reset_n = 1'b0;
    end else if (!reset_n && tick) begin
      // one extra tick: the first tick may be partial, so the hold never falls short
      if (rst_cnt >= RESET_LEN) begin
        next_reset_n = 1'b1;
      end else begin
        next_rst_cnt = rst_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mr_low_cnt <= 8'h00;
      mr_hold    <= 1'b0;
      rst_cnt    <= '0;
      reset_n    <= 1'b0;
    end else begin
      mr_low_cnt <= next_mr_low_cnt;
      mr_hold    <= next_mr_hold;
      rst_cnt    <= next_rst_cnt;
      reset_n    <= next_reset_n;
    end
  end

  // ----------------------------------------
  // windowed watchdog
  // ----------------------------------------
  wwrs_wd_state_t    wd_state;
  wwrs_wd_state_t    next_wd_state;
  logic [TCNT_W-1:0] wd_cnt;
  logic [TCNT_W-1:0] next_wd_cnt;
  logic              next_fault_n;

  // fault pulse is independent of reset; reset only holds it idle
  always_comb begin
    next_wd_state = wd_state;
    next_wd_cnt   = wd_cnt;
    next_fault_n  = watchdog_fault_pulse_n;
    if (!reset_n) begin
      next_wd_state = WD_ARMED;
      next_wd_cnt   = '0;
      next_fault_n  = 1'b1;
    end else begin
      case (wd_state)
        WD_ARMED, WD_RUN: begin
          if (tick && wd_cnt != SLOW_LIM) begin
            next_wd_cnt = wd_cnt + 1'b1;
          end
          if (kick_fall) begin
            if (wd_state == WD_RUN && wd_cnt < FAST_LIM) begin
              next_wd_state = WD_FAULT;
              next_wd_cnt   = '0;
              next_fault_n  = 1'b0;
            end else begin
              next_wd_state = WD_RUN;
              next_wd_cnt   = '0;
            end
          end else if (wd_cnt >= SLOW_LIM) begin
            next_wd_state = WD_FAULT;
            next_wd_cnt   = '0;
            next_fault_n  = 1'b0;
          end
        end
        WD_FAULT: begin
          // kick edges are dropped here
          if (tick) begin
            if (wd_cnt >= FAULT_LEN - 1'b1) begin
              next_wd_state = WD_ARMED;
              next_wd_cnt   = '0;
              next_fault_n  = 1'b1;
            end else begin
              next_wd_cnt = wd_cnt + 1'b1;
            end
          end
        end
        default: begin
          next_wd_state = WD_ARMED;
          next_wd_cnt   = '0;
          next_fault_n  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wd_state               <= WD_ARMED;
      wd_cnt                 <= '0;
      watchdog_fault_pulse_n <= 1'b1;
    end else begin
      wd_state               <= next_wd_state;
      wd_cnt                 <= next_wd_cnt;
      watchdog_fault_pulse_n <= next_fault_n;
    end
  end

endmodule
`default_nettype wire

// ---- dv/wwrs_checker_assertions.sv ----
// Purpose: port assertions for the watchdog supervisor
// Assumes: parameters handed on by the bind
// Notes:   idle time runs from the kick pin, so bounds keep slack
`timescale 1ns/100ps
`default_nettype none
module wwrs_checker
  import wwrs_pkg::*;
#(
  parameter wwrs_opt_t         WINDOW_OPT = 3'h0,
  parameter logic [TCNT_W-1:0] FAULT_LEN  = TCNT_W'(FAULT_TICKS),
  parameter logic [TCNT_W-1:0] RESET_LEN  = TCNT_W'(RESET_TICKS),
  parameter logic [TCNT_W-1:0] TICK_LEN   = TCNT_W'(TICK_CYC)
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_ok,
  input wire logic watchdog_kick_in,
  input wire logic manual_reset_n,
  input wire logic reset_n,
  input wire logic watchdog_fault_pulse_n
);
  localparam int T  = int'(TICK_LEN);
  localparam int FC = int'(FAST_US[WINDOW_OPT]) / TICK_US * T;
  localparam int SC = int'(SLOW_US[WINDOW_OPT]) / TICK_US * T;
  localparam int FL = int'(FAULT_LEN);
  localparam int RL = int'(RESET_LEN);
  logic first;
  int   idle;
  int   good;
  int   flow;
  wire  act = reset_n && watchdog_fault_pulse_n;
  // ----------
  // helpers
  // ----------
  // timer restarts whenever an output deasserts, as the device's does
  always_ff @(posedge core_clk) begin
    idle  <= (!act || !$past(act) || $fell(watchdog_kick_in)) ? 0 : idle + 1;
    first <= (!act || !$past(act)) ? 1'b1 : ($fell(watchdog_kick_in) ? 1'b0 : first);
    good  <= (rst || !supply_ok || !manual_reset_n) ? 0 : good + 1;
    flow  <= watchdog_fault_pulse_n ? 0 : flow + 1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------
  // assertions
  // ----------
  a_reset_hold_time: assert property ($rose(reset_n)
    |-> good >= RL * T && good <= (RL + 1) * T + 8)
    else $error("reset released outside hold time");
  a_supply_low_reset: assert property (!supply_ok [*4] |-> !reset_n)
    else $error("no reset on low supply");
  a_fault_quiet_rst: assert property (!reset_n [*2] |-> watchdog_fault_pulse_n)
    else $error("fault pulse during reset");
  a_fault_no_reset: assert property ($fell(watchdog_fault_pulse_n) && manual_reset_n && supply_ok
    |=> reset_n [*8])
    else $error("fault pulse caused reset");
  a_fast_edge_fault: assert property ($fell(watchdog_kick_in) && act && !first && idle < FC - T
    |-> ##[1:6] !watchdog_fault_pulse_n)
    else $error("early kick not flagged");
  a_first_edge_skip: assert property ($fell(watchdog_kick_in) && act && first
    |=> watchdog_fault_pulse_n [*6])
    else $error("first kick flagged early");
  a_slow_edge_fault: assert property (act |-> idle < SC + 2 * T)
    else $error("missing kick not flagged");
  a_pulse_length: assert property ($rose(watchdog_fault_pulse_n) && reset_n
    |-> flow >= (FL - 1) * T && flow <= (FL + 1) * T)
    else $error("fault pulse length wrong");
endmodule
bind wwrs_top wwrs_checker #(.WINDOW_OPT(WINDOW_OPT), .FAULT_LEN(FAULT_LEN), .RESET_LEN(RESET_LEN), .TICK_LEN(TICK_LEN))
  chk (.core_clk(core_clk), .rst(rst), .supply_ok(supply_ok), .watchdog_kick_in(watchdog_kick_in),
  .manual_reset_n(manual_reset_n), .reset_n(reset_n), .watchdog_fault_pulse_n(watchdog_fault_pulse_n));
`default_nettype wire

// ---- dv/wwrs_cpu_model.sv ----
// Purpose: processor model driving kick and manual reset
// Assumes: bench raises fire for one cycle per kick
// Notes:   kick set and cleared at separate points
`timescale 1ns/100ps
`default_nettype none
module wwrs_cpu_model (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic fault_n,
  input  wire logic fire,
  input  wire logic loop,
  input  wire logic mr_req_n,
  output logic      kick,
  output logic      mr_n
);
  int   hold   = 0;
  logic kick_q = 1'b1;
  // a processor held in reset does not kick
  always @(posedge core_clk) begin
    hold <= (fire && reset_n) ? 20 : (hold > 0 ? hold - 1 : 0);
    if (fire && reset_n) begin
      kick_q <= #1 1'b0;
    end else if (hold == 1) begin
      kick_q <= #1 1'b1;
    end
  end
  assign kick = kick_q;
  assign mr_n = loop ? fault_n : mr_req_n;
endmodule
`default_nettype wire

// ---- dv/tb_windowed_watchdog_reset_supervisor.sv ----
// Purpose: self-checking bench for the watchdog supervisor
// Assumes: 10-cycle tick, window option A
// Notes:   gaps keep two ticks of slack from each window edge
`timescale 1ns/100ps
`default_nettype none
module tb_windowed_watchdog_reset_supervisor;
  import wwrs_pkg::*;
  localparam int T  = 10;
  localparam int FL = 15;
  localparam int RL = 20;
  localparam int FC = int'(FAST_US[0]) / TICK_US * T;
  localparam int SC = int'(SLOW_US[0]) / TICK_US * T;
  logic core_clk, rst, supply_ok, fire, loop, mr_req_n, kick, mr_n, reset_n, fault_n;
  int   miscompares = 0;
  int   comparisons = 0;
  int   flt = 0;
  int   n;
  wwrs_top #(.WINDOW_OPT(3'h0), .FAULT_LEN(TCNT_W'(FL)), .RESET_LEN(TCNT_W'(RL)), .TICK_LEN(TCNT_W'(T))) DUT (
    .core_clk(core_clk), .rst(rst), .supply_ok(supply_ok), .watchdog_kick_in(kick),
    .manual_reset_n(mr_n), .reset_n(reset_n), .watchdog_fault_pulse_n(fault_n));
  wwrs_cpu_model cpu (.core_clk(core_clk), .reset_n(reset_n), .fault_n(fault_n), .fire(fire),
    .loop(loop), .mr_req_n(mr_req_n), .kick(kick), .mr_n(mr_n));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (fault_n === 1'b0) flt <= flt + 1;
  // ----------
  // tasks
  // ----------
  function automatic logic fault_exp(input int gap, input bit first);
    return (!first && gap < FC) || gap > SC;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t value differs", $time);
    end
  endtask
  task automatic wait_for(input bit sel, input logic v, input int lim);
    n = 0;
    while ((sel ? fault_n : reset_n) !== v) begin
      if (n == lim) begin
        miscompares++;
        $display("ERROR %0t wait ran out", $time);
        tally_and_finish();
      end
      cyc(1);
      n++;
    end
  endtask
  // kick lands gap cycles after the previous one
  task automatic kick_exp(input int gap, input bit first);
    int f0;
    f0 = flt;
    cyc(gap - 9);
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    cyc(8);
    check(flt != f0, fault_exp(gap, first));
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(96335));
    rst = 1'b1;
    supply_ok = 1'b1;
    fire = 1'b0;
    loop = 1'b0;
    mr_req_n = 1'b1;
    cyc(10);
    rst = 1'b0;
    check(reset_n, 1'b0);
    wait_for(0, 1'b1, 400);
    check(n >= RL * T, 1'b1);
    kick_exp(40, 1);
    kick_exp(FC + 2 * T, 0);
    kick_exp(SC - 3 * T, 0);
    repeat (4) kick_exp(FC + 2 * T + $urandom_range(SC - FC - 5 * T), 0);
    kick_exp(FC - 2 * T, 0);
    check(reset_n, 1'b1);
    // wait for the kick pin to rise so this one is a real edge inside the pulse
    cyc(30);
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    wait_for(1, 1'b1, 400);
    check(n + 30 > (FL - 2) * T && n + 30 < (FL + 1) * T, 1'b1);
    kick_exp(40, 1);
    kick_exp(SC + 3 * T, 0);
    wait_for(1, 1'b1, 400);
    // a 100 ns low is a glitch, a 1.5 us low a real request
    mr_req_n = 1'b0;
    cyc(10);
    mr_req_n = 1'b1;
    cyc(20);
    check(reset_n, 1'b1);
    mr_req_n = 1'b0;
    cyc(150);
    check(reset_n, 1'b0);
    mr_req_n = 1'b1;
    wait_for(0, 1'b1, 400);
    check(n >= RL * T, 1'b1);
    supply_ok = 1'b0;
    cyc(10);
    check(reset_n, 1'b0);
    check(fault_n, 1'b1);
    supply_ok = 1'b1;
    wait_for(0, 1'b1, 400);
    loop = 1'b1;
    wait_for(0, 1'b0, SC + 400);
    cyc(2);
    check(fault_n, 1'b1);
    wait_for(0, 1'b1, 400);
    check(n >= RL * T - 2, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
